// >>> hw/tmr8_top.sv
// Eight-bit timer/counter with one compare channel behind an APB slave.
`include "tmr8_params.svh"

module tmr8_top
(
   input  wire logic        MCLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        OSC_PIN_IN_I,
   output logic             OSC_PIN_OUT_O,
   input  wire logic        OVF_IRQ_ACK_I,
   input  wire logic        CMP_IRQ_ACK_I,
   output logic             OVF_IRQ_O,
   output logic             CMP_IRQ_O,
   output logic             COMPARE_OUTPUT_O,
   output logic             COMPARE_OUTPUT_EN_O
);
   tmr8_pkg::tmr8_state_t q;
   tmr8_pkg::tmr8_state_t n;

   logic       setup;
   logic       acc;
   logic       wr;
   logic       ctrl_wr;
   logic       cnt_wr;
   logic       cmp_wr;
   logic       flg_wr;
   logic       msk_wr;
   logic       pwm;
   logic       src_edge;
   logic       tick;
   logic       match;
   logic       hit;
   logic       bottom;
   logic       at_max;
   logic [7:0] top;
   logic [9:0] div_mask;

   // Non-PWM action of a match on the output: toggle, clear or set.
   function automatic logic np_act(input logic [1:0] com, input logic oc);
      logic r;
      r = oc;
      unique case (com)
         2'h0: r = oc;
         2'h1: r = ~oc;
         2'h2: r = 1'b0;
         2'h3: r = 1'b1;
      endcase
      return r;
   endfunction

   assign setup   = PSEL_I & ~PENABLE_I;
   assign acc     = PSEL_I & PENABLE_I & q.rdy;
   assign wr      = acc & PWRITE_I & ~q.slverr;
   assign ctrl_wr = wr & (PADDR_I == `TMR8_OFF_CTRL);
   assign cnt_wr  = wr & (PADDR_I == `TMR8_OFF_CNT);
   assign cmp_wr  = wr & (PADDR_I == `TMR8_OFF_CMP);
   assign flg_wr  = wr & (PADDR_I == `TMR8_OFF_FLAG);
   assign msk_wr  = wr & (PADDR_I == `TMR8_OFF_MASK);

   assign pwm    = (q.wgm == tmr8_pkg::TMR8_PHASE) | (q.wgm == tmr8_pkg::TMR8_FAST);
   assign bottom = (q.cnt == `TMR8_BOTTOM);
   assign at_max = (q.cnt == `TMR8_MAX);
   assign top    = (q.wgm == tmr8_pkg::TMR8_CTC) ? q.ocr : `TMR8_MAX;
   assign match  = (q.cnt == q.ocr);
   assign hit    = tick & match & ~q.blk;

   // Crystal edges are taken from the filtered level, so one rising pin edge is one prescaler step.
   assign src_edge = q.asel ? ((q.s2 == q.s3) & q.s3 & ~q.filt) : 1'b1;

   always_comb
   begin
      unique case (q.css)
         3'h0: div_mask = `TMR8_DIV_1;
         3'h1: div_mask = `TMR8_DIV_1;
         3'h2: div_mask = `TMR8_DIV_8;
         3'h3: div_mask = `TMR8_DIV_32;
         3'h4: div_mask = `TMR8_DIV_64;
         3'h5: div_mask = `TMR8_DIV_128;
         3'h6: div_mask = `TMR8_DIV_256;
         3'h7: div_mask = `TMR8_DIV_1024;
      endcase
   end

   assign tick = (q.css != 3'h0) & src_edge & ((q.presc & div_mask) == div_mask);

   always_comb
   begin
      n = q;
      n.s1 = OSC_PIN_IN_I;
      n.s2 = q.s1;
      n.s3 = q.s2;
      if (q.s2 == q.s3)
      begin
         n.filt = q.s3;
      end
      n.oscout = ~q.filt;
      if ((q.css != 3'h0) && src_edge)
      begin
         n.presc = q.presc + 10'h001;
      end

      // Clears go first so that a flag set in the same cycle survives them.
      if (OVF_IRQ_ACK_I || (flg_wr && PWDATA_I[`TMR8_F_OVF]))
      begin
         n.ovf = 1'b0;
      end
      if (CMP_IRQ_ACK_I || (flg_wr && PWDATA_I[`TMR8_F_CMPF]))
      begin
         n.cmpf = 1'b0;
      end

      if (tick)
      begin
         n.blk = 1'b0;
         if (hit)
         begin
            n.cmpf = 1'b1;
         end
         unique case (q.wgm)
            tmr8_pkg::TMR8_NORMAL:
            begin
               n.cnt = q.cnt + 8'h01;
               if (at_max)
               begin
                  n.ovf = 1'b1;
               end
               if (hit)
               begin
                  n.oc = np_act(q.com, q.oc);
               end
            end
            tmr8_pkg::TMR8_CTC:
            begin
               if (hit && (q.cnt == top))
               begin
                  n.cnt = `TMR8_BOTTOM;
               end
               else
               begin
                  n.cnt = q.cnt + 8'h01;
               end
               if (at_max)
               begin
                  n.ovf = 1'b1;
               end
               if (hit)
               begin
                  n.oc = np_act(q.com, q.oc);
               end
            end
            tmr8_pkg::TMR8_FAST:
            begin
               n.cnt = q.cnt + 8'h01;
               if (hit && q.com[1])
               begin
                  n.oc = q.com[0];
               end
               if (at_max)
               begin
                  n.ovf = 1'b1;
                  n.ocr = q.obuf;
                  if (q.com[1])
                  begin
                     n.oc = ~q.com[0];
                  end
               end
            end
            tmr8_pkg::TMR8_PHASE:
            begin
               if (q.dir == tmr8_pkg::TMR8_UP)
               begin
                  if (at_max)
                  begin
                     n.dir = tmr8_pkg::TMR8_DOWN;
                     n.cnt = q.cnt - 8'h01;
                     n.ocr = q.obuf;
                  end
                  else
                  begin
                     n.cnt = q.cnt + 8'h01;
                  end
                  if (hit && q.com[1])
                  begin
                     n.oc = q.com[0];
                  end
               end
               else
               begin
                  if (bottom)
                  begin
                     n.dir = tmr8_pkg::TMR8_UP;
                     n.cnt = q.cnt + 8'h01;
                     n.ovf = 1'b1;
                  end
                  else
                  begin
                     n.cnt = q.cnt - 8'h01;
                  end
                  if (hit && q.com[1])
                  begin
                     n.oc = ~q.com[0];
                  end
               end
            end
         endcase
      end

      // Software writes come last: a counter write overrides the tick's new count, but not the flags or output that the tick set.
      if (ctrl_wr)
      begin
         n.wgm  = tmr8_pkg::tmr8_wgm_t'(PWDATA_I[`TMR8_F_WGM +: 2]);
         n.com  = PWDATA_I[`TMR8_F_COM +: 2];
         n.css  = PWDATA_I[`TMR8_F_CSS +: 3];
         n.asel = PWDATA_I[`TMR8_F_ASEL];
         if (PWDATA_I[`TMR8_F_WGM +: 2] != 2'h1)
         begin
            n.dir = tmr8_pkg::TMR8_UP;
         end
         if (PWDATA_I[`TMR8_F_FORCE] && !PWDATA_I[`TMR8_F_WGM])
         begin
            n.oc = np_act(PWDATA_I[`TMR8_F_COM +: 2], q.oc);
         end
      end
      if (cnt_wr)
      begin
         n.cnt = PWDATA_I[7:0];
         n.blk = 1'b1;
      end
      if (cmp_wr)
      begin
         n.obuf = PWDATA_I[7:0];
         if (!pwm)
         begin
            n.ocr = PWDATA_I[7:0];
         end
      end
      if (msk_wr)
      begin
         n.ovf_en = PWDATA_I[`TMR8_F_OVF];
         n.cmp_en = PWDATA_I[`TMR8_F_CMPF];
      end

      n.ovf_irq = n.ovf & n.ovf_en;
      n.cmp_irq = n.cmpf & n.cmp_en;
      n.oe      = (n.com != 2'h0);

      // Read data is captured in the setup cycle; the answer comes one cycle later.
      n.rdy    = setup;
      n.slverr = 1'b0;
      n.rdata  = 32'h0000_0000;
      if (setup)
      begin
         unique case (PADDR_I)
            `TMR8_OFF_CTRL:
            begin
               n.rdata[`TMR8_F_WGM +: 2] = q.wgm;
               n.rdata[`TMR8_F_COM +: 2] = q.com;
               n.rdata[`TMR8_F_CSS +: 3] = q.css;
               n.rdata[`TMR8_F_ASEL]     = q.asel;
            end
            `TMR8_OFF_CNT:  n.rdata[7:0] = q.cnt;
            `TMR8_OFF_CMP:  n.rdata[7:0] = pwm ? q.obuf : q.ocr;
            `TMR8_OFF_FLAG:
            begin
               n.rdata[`TMR8_F_OVF]  = q.ovf;
               n.rdata[`TMR8_F_CMPF] = q.cmpf;
            end
            `TMR8_OFF_MASK:
            begin
               n.rdata[`TMR8_F_OVF]  = q.ovf_en;
               n.rdata[`TMR8_F_CMPF] = q.cmp_en;
            end
            `TMR8_OFF_ACT:  n.rdata[7:0] = q.ocr;
            default:        n.slverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign PRDATA_O            = q.rdata;
   assign PREADY_O            = q.rdy;
   assign PSLVERR_O           = q.slverr;
   assign OSC_PIN_OUT_O       = q.oscout;
   assign OVF_IRQ_O           = q.ovf_irq;
   assign CMP_IRQ_O           = q.cmp_irq;
   assign COMPARE_OUTPUT_O    = q.oc;
   assign COMPARE_OUTPUT_EN_O = q.oe;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   property p_stop;
      (q.css == 3'h0) && !cnt_wr |=> $stable(q.cnt);
   endproperty
   a_stop: assert property (p_stop) else $error("Counter moved with no clock.");

   property p_cnt_wr;
      cnt_wr |=> (q.cnt == $past(PWDATA_I[7:0])) && q.blk;
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("Counter write lost.");

   property p_norm_wrap;
      tick && (q.wgm == tmr8_pkg::TMR8_NORMAL) && at_max && !cnt_wr
         |=> (q.cnt == 8'h00) && q.ovf;
   endproperty
   a_norm_wrap: assert property (p_norm_wrap) else $error("Normal wrap wrong.");

   property p_cmp_set;
      tick && match && !q.blk |=> q.cmpf;
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("Compare flag not set.");

   property p_block;
      tick && q.blk && !q.cmpf |=> !q.cmpf;
   endproperty
   a_block: assert property (p_block) else $error("Blocked match set flag.");

   property p_w1c;
      flg_wr && PWDATA_I[`TMR8_F_CMPF] && !hit |=> !q.cmpf;
   endproperty
   a_w1c: assert property (p_w1c) else $error("Compare flag not cleared.");

   property p_ack;
      CMP_IRQ_ACK_I && !hit |=> !q.cmpf && !CMP_IRQ_O;
   endproperty
   a_ack: assert property (p_ack) else $error("Service did not clear flag.");

   property p_force;
      ctrl_wr && PWDATA_I[`TMR8_F_FORCE] && (PWDATA_I[1:0] == 2'h2)
         && (PWDATA_I[5:4] == 2'h1) && !hit
         |=> (q.oc != $past(q.oc)) && (q.cmpf == $past(q.cmpf));
   endproperty
   a_force: assert property (p_force) else $error("Force strobe misbehaved.");

   property p_ctc_clr;
      tick && (q.wgm == tmr8_pkg::TMR8_CTC) && match && !q.blk && !cnt_wr
         |=> q.cnt == 8'h00;
   endproperty
   a_ctc_clr: assert property (p_ctc_clr) else $error("CTC did not clear.");

   property p_buf;
      cmp_wr && pwm && !tick |=> (q.obuf == $past(PWDATA_I[7:0])) && $stable(q.ocr);
   endproperty
   a_buf: assert property (p_buf) else $error("PWM compare not buffered.");

   c_norm_ovf: cover property (tick && (q.wgm == tmr8_pkg::TMR8_NORMAL) && at_max);
   c_fast_hit: cover property (hit && (q.wgm == tmr8_pkg::TMR8_FAST) ##[1:600] at_max && tick);
   c_phase_dn: cover property (tick && (q.dir == tmr8_pkg::TMR8_DOWN) && bottom);
   c_force:    cover property (ctrl_wr && PWDATA_I[`TMR8_F_FORCE]);
endmodule

// >>> pkg/tmr8_params.svh
// Offsets, field positions, reset values and prescaler masks of the 8-bit timer.
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH
`define TMR8_OFF_CTRL   8'h00
`define TMR8_OFF_CNT    8'h04
`define TMR8_OFF_CMP    8'h08
`define TMR8_OFF_FLAG   8'h0C
`define TMR8_OFF_MASK   8'h10
`define TMR8_OFF_ACT    8'h14
`define TMR8_F_WGM      0
`define TMR8_F_COM      4
`define TMR8_F_FORCE    7
`define TMR8_F_CSS      8
`define TMR8_F_ASEL     12
`define TMR8_F_OVF      0
`define TMR8_F_CMPF     1
`define TMR8_BOTTOM     8'h00
`define TMR8_MAX        8'hFF
`define TMR8_RST_CNT    8'h00
`define TMR8_RST_CMP    8'h00
`define TMR8_DIV_1      10'h000
`define TMR8_DIV_8      10'h007
`define TMR8_DIV_32     10'h01F
`define TMR8_DIV_64     10'h03F
`define TMR8_DIV_128    10'h07F
`define TMR8_DIV_256    10'h0FF
`define TMR8_DIV_1024   10'h3FF
`endif

// >>> pkg/tmr8_pkg.sv
// Types shared by the 8-bit timer design.
package tmr8_pkg;
   typedef enum logic [1:0] {
      TMR8_NORMAL = 2'h0,
      TMR8_PHASE  = 2'h1,
      TMR8_CTC    = 2'h2,
      TMR8_FAST   = 2'h3
   } tmr8_wgm_t;
   typedef enum logic {
      TMR8_UP   = 1'h0,
      TMR8_DOWN = 1'h1
   } tmr8_dir_t;
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        s3;
      logic        filt;
      logic [9:0]  presc;
      logic [7:0]  cnt;
      logic [7:0]  ocr;
      logic [7:0]  obuf;
      tmr8_dir_t   dir;
      logic        blk;
      logic        oc;
      logic        ovf;
      logic        cmpf;
      logic        ovf_en;
      logic        cmp_en;
      tmr8_wgm_t   wgm;
      logic [1:0]  com;
      logic [2:0]  css;
      logic        asel;
      logic        oe;
      logic [31:0] rdata;
      logic        rdy;
      logic        slverr;
      logic        ovf_irq;
      logic        cmp_irq;
      logic        oscout;
   } tmr8_state_t;
endpackage

// >>> bench/tb_timer8_single_compare_unit.sv
// Self-checking testbench of the 8-bit timer, driven through its APB register port.
`include "tmr8_params.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module tb_timer8_single_compare_unit;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        osc_in;
   logic        ovf_ack;
   logic        cmp_ack;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         osc_out;
   wire         ovf_irq;
   wire         cmp_irq;
   wire         co;
   wire         co_en;
   int          fail_count;
   int          checks;
   logic [31:0] v;
   logic        e;

   tmr8_top uut
   (
      .MCLK_I              (mclk),
      .SYS_RST_I           (sys_rst),
      .PSEL_I              (psel),
      .PENABLE_I           (penable),
      .PWRITE_I            (pwrite),
      .PADDR_I             (paddr),
      .PWDATA_I            (pwdata),
      .PRDATA_O            (prdata),
      .PREADY_O            (pready),
      .PSLVERR_O           (pslverr),
      .OSC_PIN_IN_I        (osc_in),
      .OSC_PIN_OUT_O       (osc_out),
      .OVF_IRQ_ACK_I       (ovf_ack),
      .CMP_IRQ_ACK_I       (cmp_ack),
      .OVF_IRQ_O           (ovf_irq),
      .CMP_IRQ_O           (cmp_irq),
      .COMPARE_OUTPUT_O    (co),
      .COMPARE_OUTPUT_EN_O (co_en)
   );

   initial
   begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end

   // Control word: mode, output mode, force strobe, clock select, crystal select.
   function automatic logic [31:0] ctl(input logic [1:0] w, input logic [1:0] c,
                                       input logic f, input logic [2:0] s, input logic a);
      return {19'h0, a, 1'h0, s, f, 1'h0, c, 2'h0, w};
   endfunction

   // The request is held until pready is seen high at a rising edge, then released.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      `CHK(pready, 1'h1)
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        x;
      apb(1'h1, a, d, r, x);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        x;
      apb(1'h0, a, 32'h0, r, x);
      `CHK(r, exp)
   endtask

   // Loads the counter, lets it run a few ticks in normal mode, then stops it.
   task automatic runm(input logic [7:0] c);
      wr(`TMR8_OFF_CNT, {24'h0, c});
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h1, 1'h0));
      repeat (4) @(posedge mclk);
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h0, 1'h0));
   endtask

   task automatic ack(input logic ovf);
      @(posedge mclk);
      if (ovf)
         ovf_ack <= 1'h1;
      else
         cmp_ack <= 1'h1;
      @(posedge mclk);
      ovf_ack <= 1'h0;
      cmp_ack <= 1'h0;
      repeat (2) @(posedge mclk);
   endtask

   task automatic results();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A hang is cut short long after the sequence should have ended.
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      results();
   end

   initial
   begin
      sys_rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
      pwdata = 32'h0; osc_in = 1'h0; ovf_ack = 1'h0; cmp_ack = 1'h0;
      fail_count = 0;
      checks = 0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'h0;
      rd(`TMR8_OFF_CTRL, 32'h0);
      rd(`TMR8_OFF_CMP, 32'h0);
      rd(`TMR8_OFF_FLAG, 32'h0);
      rd(`TMR8_OFF_MASK, 32'h0);
      apb(1'h0, 8'h18, 32'h0, v, e);
      `CHK({e, v}, 33'h100000000)
      wr(`TMR8_OFF_CNT, 32'h10);
      repeat (20) @(posedge mclk);
      rd(`TMR8_OFF_CNT, 32'h10);
      wr(`TMR8_OFF_CMP, 32'h10);
      rd(`TMR8_OFF_ACT, 32'h10);
      runm(8'h10);
      rd(`TMR8_OFF_FLAG, 32'h0);
      runm(8'h0E);
      apb(1'h0, `TMR8_OFF_CNT, 32'h0, v, e);
      `CHK(v[7:0] inside {[8'h11:8'h1A]}, 1'h1)
      rd(`TMR8_OFF_FLAG, 32'h2);
      wr(`TMR8_OFF_MASK, 32'h2);
      repeat (2) @(posedge mclk);
      `CHK({cmp_irq, ovf_irq}, 2'h2)
      wr(`TMR8_OFF_FLAG, 32'h0);
      rd(`TMR8_OFF_FLAG, 32'h2);
      wr(`TMR8_OFF_FLAG, 32'h2);
      rd(`TMR8_OFF_FLAG, 32'h0);
      runm(8'h0E);
      ack(1'h0);
      `CHK(cmp_irq, 1'h0)
      rd(`TMR8_OFF_FLAG, 32'h0);
      // Overflow in normal mode, masked and unmasked, then serviced.
      runm(8'hFD);
      rd(`TMR8_OFF_FLAG, 32'h1);
      wr(`TMR8_OFF_MASK, 32'h1);
      repeat (2) @(posedge mclk);
      `CHK(ovf_irq, 1'h1)
      ack(1'h1);
      `CHK(ovf_irq, 1'h0)
      // Clear-on-match keeps the count at or below the compare value.
      wr(`TMR8_OFF_CMP, 32'h05);
      wr(`TMR8_OFF_CNT, 32'h00);
      wr(`TMR8_OFF_CTRL, ctl(2'h2, 2'h0, 1'h0, 3'h1, 1'h0));
      repeat (40) @(posedge mclk);
      wr(`TMR8_OFF_CTRL, ctl(2'h2, 2'h0, 1'h0, 3'h0, 1'h0));
      apb(1'h0, `TMR8_OFF_CNT, 32'h0, v, e);
      `CHK(v <= 32'h05, 1'h1)
      rd(`TMR8_OFF_FLAG, 32'h2);
      wr(`TMR8_OFF_FLAG, 32'h3);
      // Forced compares: toggle, no action, ignored in PWM, toggle again in normal mode.
      wr(`TMR8_OFF_CTRL, ctl(2'h2, 2'h1, 1'h1, 3'h0, 1'h0));
      repeat (2) @(posedge mclk);
      `CHK({co, co_en}, 2'h3)
      rd(`TMR8_OFF_FLAG, 32'h0);
      rd(`TMR8_OFF_CNT, v);
      wr(`TMR8_OFF_CTRL, ctl(2'h2, 2'h0, 1'h1, 3'h0, 1'h0));
      repeat (2) @(posedge mclk);
      `CHK({co, co_en}, 2'h2)
      wr(`TMR8_OFF_CTRL, ctl(2'h3, 2'h1, 1'h1, 3'h0, 1'h0));
      repeat (2) @(posedge mclk);
      `CHK(co, 1'h1)
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h1, 1'h1, 3'h0, 1'h0));
      repeat (2) @(posedge mclk);
      `CHK(co, 1'h0)
      // Fast PWM: buffered compare loads at bottom, output set at bottom.
      wr(`TMR8_OFF_CTRL, ctl(2'h3, 2'h2, 1'h0, 3'h0, 1'h0));
      wr(`TMR8_OFF_CMP, 32'h40);
      rd(`TMR8_OFF_CMP, 32'h40);
      rd(`TMR8_OFF_ACT, 32'h05);
      wr(`TMR8_OFF_CNT, 32'hFC);
      wr(`TMR8_OFF_CTRL, ctl(2'h3, 2'h2, 1'h0, 3'h1, 1'h0));
      repeat (8) @(posedge mclk);
      wr(`TMR8_OFF_CTRL, ctl(2'h3, 2'h2, 1'h0, 3'h0, 1'h0));
      rd(`TMR8_OFF_ACT, 32'h40);
      `CHK(co, 1'h1)
      rd(`TMR8_OFF_FLAG, 32'h1);
      wr(`TMR8_OFF_FLAG, 32'h3);
      // Phase correct: no wrap at the top, overflow only back at bottom.
      // The up-count passes the compare value, so the compare flag is already up.
      wr(`TMR8_OFF_CNT, 32'h02);
      wr(`TMR8_OFF_CTRL, ctl(2'h1, 2'h0, 1'h0, 3'h1, 1'h0));
      repeat (300) @(posedge mclk);
      rd(`TMR8_OFF_FLAG, 32'h2);
      repeat (260) @(posedge mclk);
      apb(1'h0, `TMR8_OFF_FLAG, 32'h0, v, e);
      `CHK(v[0], 1'h1)
      // Divide by eight: forty clocks of run time give exactly five ticks.
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h0, 1'h0));
      wr(`TMR8_OFF_CNT, 32'h00);
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h2, 1'h0));
      repeat (37) @(posedge mclk);
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h0, 1'h0));
      rd(`TMR8_OFF_CNT, 32'h05);
      // Crystal clock: one count per rising edge of the oscillator pin.
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h0, 1'h0));
      wr(`TMR8_OFF_CNT, 32'h00);
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h1, 1'h1));
      repeat (10)
      begin
         repeat (8) @(posedge mclk);
         osc_in <= 1'h1;
         repeat (8) @(posedge mclk);
         osc_in <= 1'h0;
      end
      repeat (8) @(posedge mclk);
      `CHK(osc_out, 1'h1)
      wr(`TMR8_OFF_CTRL, ctl(2'h0, 2'h0, 1'h0, 3'h0, 1'h0));
      rd(`TMR8_OFF_CNT, 32'h0A);
      results();
   end
endmodule
